// File: common/sfc_pkg.sv
// Constants, types and opcode decode for the serial command framer
package sfc_pkg;
   localparam int SYNC_W = 4;
   localparam int PAGE_W = 11;
   localparam int BYTE_W = 9;
   localparam int PAGE_LSB = 9;
   localparam int PAGE_MSB = 19;
   localparam int BYTE_MSB = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam logic [2:0] DUMMY_NONE = 3'h0;
   localparam logic [2:0] DUMMY_FAST = 3'h1;
   localparam logic [2:0] DUMMY_CONT = 3'h4;
   localparam logic [5:0] DBITS_FAST = 6'h08;
   localparam logic [5:0] DBITS_CONT = 6'h20;
   localparam logic MODE3_RST = 1'b1;
   // Page bits kept per opcode; the rest of the page field is don't-care
   localparam logic [PAGE_W-1:0] PAGE_KEEP_ALL = 11'h7ff;
   localparam logic [PAGE_W-1:0] PAGE_KEEP_BLK = 11'h7f8;
   localparam logic [PAGE_W-1:0] PAGE_KEEP_SEC = 11'h700;
   // Opcodes that carry a page and byte address
   localparam logic [7:0] OP_ARRAY_RD = 8'h03, OP_ARRAY_RD_FAST = 8'h0b;
   localparam logic [7:0] OP_PAGE_RD = 8'hd2, OP_CONT_RD_OLD = 8'he8;
   localparam logic [7:0] OP_PROG_B1 = 8'h82, OP_PROG_B2 = 8'h85;
   // Opcodes that carry only a page address
   localparam logic [7:0] OP_P50 = 8'h50, OP_P53 = 8'h53, OP_P55 = 8'h55;
   localparam logic [7:0] OP_P58 = 8'h58, OP_P59 = 8'h59, OP_P60 = 8'h60;
   localparam logic [7:0] OP_P61 = 8'h61, OP_P7C = 8'h7c, OP_P81 = 8'h81;
   localparam logic [7:0] OP_P83 = 8'h83, OP_P86 = 8'h86, OP_P88 = 8'h88;
   localparam logic [7:0] OP_P89 = 8'h89;
   // Buffer-only opcodes
   localparam logic [7:0] OP_BUF1_WR = 8'h84, OP_BUF2_WR = 8'h87;
   localparam logic [7:0] OP_BUF1_RD = 8'hd1, OP_BUF2_RD = 8'hd3;
   localparam logic [7:0] OP_BUF1_RDF = 8'hd4, OP_BUF2_RDF = 8'hd6;
   // Three address bytes, every bit ignored
   localparam logic [7:0] OP_SEC_PROG = 8'h77;
   // No address
   localparam logic [7:0] OP_ID_RD = 8'h9f, OP_STATUS_RD = 8'hd7;
   localparam logic [7:0] OP_SLEEP = 8'hb9, OP_WAKE = 8'hab;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPC = 3'b001,
      ST_ADDR = 3'b011,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b110,
      ST_SKIP = 3'b111
   } sfc_state_type;

   typedef struct packed {
      logic known;
      logic has_addr;
      logic use_page;
      logic use_byte;
      logic reads;
      logic [2:0] dummy;
   } sfc_info_type;

   function automatic sfc_info_type sfc_decode(input logic [7:0] op);
      sfc_info_type i;
      i = '{known: 1'b1, has_addr: 1'b1, use_page: 1'b0, use_byte: 1'b0,
            reads: 1'b0, dummy: DUMMY_NONE};
      case (op)
         OP_ARRAY_RD, OP_PROG_B1, OP_PROG_B2: begin
            i.use_page = 1'b1;
            i.use_byte = 1'b1;
            i.reads = (op == OP_ARRAY_RD);
         end
         OP_ARRAY_RD_FAST: begin
            i.use_page = 1'b1;
            i.use_byte = 1'b1;
            i.reads = 1'b1;
            i.dummy = DUMMY_FAST;
         end
         OP_PAGE_RD, OP_CONT_RD_OLD: begin
            i.use_page = 1'b1;
            i.use_byte = 1'b1;
            i.reads = 1'b1;
            i.dummy = DUMMY_CONT;
         end
         OP_P50, OP_P53, OP_P55, OP_P58, OP_P59, OP_P60, OP_P61, OP_P7C,
         OP_P81, OP_P83, OP_P86, OP_P88, OP_P89: begin
            i.use_page = 1'b1;
         end
         OP_BUF1_WR, OP_BUF2_WR, OP_BUF1_RD, OP_BUF2_RD: begin
            i.use_byte = 1'b1;
            i.reads = (op == OP_BUF1_RD) || (op == OP_BUF2_RD);
         end
         OP_BUF1_RDF, OP_BUF2_RDF: begin
            i.use_byte = 1'b1;
            i.reads = 1'b1;
            i.dummy = DUMMY_FAST;
         end
         OP_SEC_PROG: begin
            i.has_addr = 1'b1;
         end
         OP_ID_RD, OP_STATUS_RD: begin
            i.has_addr = 1'b0;
            i.reads = 1'b1;
         end
         OP_SLEEP, OP_WAKE: begin
            i.has_addr = 1'b0;
         end
         default: begin
            i.known = 1'b0;
            i.has_addr = 1'b0;
         end
      endcase
      return i;
   endfunction
endpackage

// File: hdl/sfc_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
module sfc_sync #(
   parameter int W = 1
) (
   input wire logic clock, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic [W-1:0] d, // Asynchronous inputs
   input wire logic [W-1:0] init, // Constant reset value
   output logic [W-1:0] q // Synchronised outputs
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sfc_sync_state_type;

   sfc_sync_state_type r_reg;
   sfc_sync_state_type r_next;

   always_comb begin
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end

   // Init is tied to constants by the caller
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg <= {init, init};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.s2;
endmodule

// File: hdl/sfc_framer.sv
// Serial flash command framer: frame decode, mode pick, power-up state
// Summary of operation
// - opcode, then 4 reserved, 11 page, 9 byte
// - page commands take page bits, ignore don't-cares
// - buffer commands use only nine byte bits
// - reset leaves the device in mode 3
// - output stays high impedance after reset
// - commands only after a select falling edge
// - each select fall outside power-on reset samples clock idle level
// - power-on reset ignores every command
// - after power-up, idle in standby
module sfc_framer
   import sfc_pkg::*;
(
   input wire logic clock, // System clock, 20 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic cs_n_pin, // Device select pin, active low
   input wire logic sck_pin, // Serial clock pin
   input wire logic si_pin, // Serial data in pin
   input wire logic por_active, // Internal power-on reset, active high
   input wire logic [7:0] rd_data, // Next output byte, valid with rd_req
   output logic rd_req, // Pulse: rd_data is taken this cycle
   output logic so_out, // Serial data out level
   output logic so_oe_n, // Serial out enable, low drives the pin
   output logic cmd_valid, // Pulse: header complete
   output logic [7:0] cmd_opcode, // Opcode of the frame
   output logic [PAGE_W-1:0] cmd_page, // Page address, zero if unused
   output logic [BYTE_W-1:0] cmd_byte, // Byte address, zero if unused
   output logic wr_valid, // Pulse: one data byte received
   output logic [7:0] wr_data, // Received data byte
   output logic frame_end, // Pulse: select rose on an open frame
   output logic mode3, // Clock mode in use, high for mode 3
   output logic standby // No frame in progress
);
   typedef struct packed {
      sfc_state_type st;
      logic sck_d;
      logic cs_d;
      logic armed;
      logic mode3;
      logic [7:0] opc;
      sfc_info_type info;
      logic [7:0] rx;
      logic [2:0] bit_cnt;
      logic [1:0] abyte_cnt;
      logic [2:0] dummy_cnt;
      logic [5:0] dbits;
      logic [23:0] addr;
      logic [7:0] tx;
      logic so_oe_n;
      logic shift_pend;
      logic reload_pend;
      logic cmd_valid;
      logic [PAGE_W-1:0] cmd_page;
      logic [BYTE_W-1:0] cmd_byte;
      logic wr_valid;
      logic [7:0] wr_data;
      logic frame_end;
   } sfc_framer_state_type;

   localparam sfc_framer_state_type RST_STATE = '{
      st: ST_IDLE, sck_d: 1'b1, cs_d: 1'b0, armed: 1'b0, mode3: MODE3_RST,
      so_oe_n: 1'b1, default: '0};

   sfc_framer_state_type r_reg;
   sfc_framer_state_type r_next;
   logic [SYNC_W-1:0] sync_q;
   logic por_s;
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic rd_req_c;

   // Reset values: POR held, select low, clock idle high
   // Select starts low so a pin held low through reset gives no edge
   sfc_sync #(.W(SYNC_W)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .d({por_active, cs_n_pin, sck_pin, si_pin}),
      .init(4'ha),
      .q(sync_q)
   );
   assign {por_s, cs_s, sck_s, si_s} = sync_q;

   function automatic logic [PAGE_W-1:0] page_keep(input logic [7:0] o);
      case (o)
         OP_P50: page_keep = PAGE_KEEP_BLK;
         OP_P7C: page_keep = PAGE_KEEP_SEC;
         default: page_keep = PAGE_KEEP_ALL;
      endcase
   endfunction

   always_comb begin
      logic rise;
      logic fall;
      logic done;
      logic [7:0] rx_byte;
      logic [7:0] op;
      logic [23:0] hdr_addr;
      sfc_info_type inf;
      rise = sck_s & ~r_reg.sck_d;
      fall = ~sck_s & r_reg.sck_d;
      done = 1'b0;
      rx_byte = {r_reg.rx[6:0], si_s};
      op = (r_reg.st == ST_OPC) ? rx_byte : r_reg.opc;
      inf = (r_reg.st == ST_OPC) ? sfc_decode(rx_byte) : r_reg.info;
      hdr_addr = (r_reg.st == ST_ADDR) ? {r_reg.addr[15:0], rx_byte}
                                       : r_reg.addr;
      r_next = r_reg;
      rd_req_c = 1'b0;
      r_next.cmd_valid = 1'b0;
      r_next.wr_valid = 1'b0;
      r_next.frame_end = 1'b0;
      r_next.sck_d = sck_s;
      r_next.cs_d = cs_s;
      if (por_s) begin
         // Nothing is heard until the internal reset lets go
         r_next.st = ST_IDLE;
         r_next.armed = 1'b0;
         r_next.mode3 = MODE3_RST;
         r_next.so_oe_n = 1'b1;
      end else if (cs_s) begin
         r_next.frame_end = (r_reg.st != ST_IDLE);
         r_next.st = ST_IDLE;
         r_next.so_oe_n = 1'b1;
      end else if (!cs_s && r_reg.cs_d) begin
         r_next.armed = 1'b1;
         r_next.mode3 = sck_s;
         r_next.st = ST_OPC;
         r_next.bit_cnt = '0;
         r_next.dbits = '0;
         r_next.shift_pend = 1'b0;
         r_next.reload_pend = 1'b0;
      end else if (r_reg.armed && rise) begin
         r_next.rx = rx_byte;
         r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
         case (r_reg.st)
            ST_OPC: begin
               if (r_reg.bit_cnt == BIT_LAST) begin
                  r_next.opc = rx_byte;
                  r_next.info = inf;
                  r_next.abyte_cnt = '0;
                  if (!inf.known) begin
                     r_next.st = ST_SKIP;
                  end else if (inf.has_addr) begin
                     r_next.st = ST_ADDR;
                  end else begin
                     done = 1'b1;
                  end
               end
            end
            ST_ADDR: begin
               if (r_reg.bit_cnt == BIT_LAST) begin
                  r_next.addr = hdr_addr;
                  r_next.abyte_cnt = r_reg.abyte_cnt + 2'h1;
                  if (r_reg.abyte_cnt == ADDR_LAST) begin
                     r_next.dummy_cnt = '0;
                     if (inf.dummy != DUMMY_NONE) begin
                        r_next.st = ST_DUMMY;
                     end else begin
                        done = 1'b1;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               r_next.dbits = r_reg.dbits + 6'h1;
               if (r_reg.bit_cnt == BIT_LAST) begin
                  r_next.dummy_cnt = r_reg.dummy_cnt + 3'h1;
                  // Dummy byte count per opcode
                  if (r_reg.dummy_cnt == inf.dummy - 3'h1) begin
                     done = 1'b1;
                  end
               end
            end
            ST_DATA: begin
               if (inf.reads) begin
                  r_next.shift_pend = 1'b1;
                  r_next.reload_pend = (r_reg.bit_cnt == BIT_LAST);
               end else if (r_reg.bit_cnt == BIT_LAST) begin
                  r_next.wr_valid = 1'b1;
                  r_next.wr_data = rx_byte;
               end
            end
            default: begin
               r_next.st = r_reg.st;
            end
         endcase
         if (done) begin
            r_next.st = ST_DATA;
            r_next.cmd_valid = 1'b1;
            r_next.cmd_page = inf.use_page ?
               hdr_addr[PAGE_MSB:PAGE_LSB] & page_keep(op) : '0;
            r_next.cmd_byte = inf.use_byte ? hdr_addr[BYTE_MSB:0] : '0;
            // First output bit must stand before the first data rise
            r_next.shift_pend = inf.reads;
            r_next.reload_pend = inf.reads;
         end
      end else if (r_reg.armed && fall && r_reg.st == ST_DATA &&
                   r_reg.info.reads && r_reg.shift_pend) begin
         // Change only on falls so the host samples on rises
         r_next.shift_pend = 1'b0;
         if (r_reg.reload_pend) begin
            rd_req_c = 1'b1;
            r_next.tx = rd_data;
            r_next.reload_pend = 1'b0;
            r_next.so_oe_n = 1'b0;
         end else begin
            r_next.tx = {r_reg.tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         r_reg <= RST_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rd_req = rd_req_c;
   assign so_out = r_reg.tx[7];
   assign so_oe_n = r_reg.so_oe_n;
   assign cmd_valid = r_reg.cmd_valid;
   assign cmd_opcode = r_reg.opc;
   assign cmd_page = r_reg.cmd_page;
   assign cmd_byte = r_reg.cmd_byte;
   assign wr_valid = r_reg.wr_valid;
   assign wr_data = r_reg.wr_data;
   assign frame_end = r_reg.frame_end;
   assign mode3 = r_reg.mode3;
   assign standby = (r_reg.st == ST_IDLE);

   sequence s_dummy_to_data;
      (r_reg.st == ST_DUMMY) ##1 (r_reg.st == ST_DATA);
   endsequence

   property p_por_quiet;
      @(posedge clock) disable iff (!rstn)
         por_s |=> (!cmd_valid && so_oe_n);
   endproperty
   a_por_quiet: assert property (p_por_quiet)
      else $error("command or output during power-on reset");

   property p_desel_hiz;
      @(posedge clock) disable iff (!rstn)
         cs_s |=> so_oe_n;
   endproperty
   a_desel_hiz: assert property (p_desel_hiz)
      else $error("output driven while deselected");

   property p_mode_pick;
      @(posedge clock) disable iff (!rstn)
         (!cs_s && r_reg.cs_d && !por_s) |=> (mode3 == $past(sck_s));
   endproperty
   a_mode_pick: assert property (p_mode_pick)
      else $error("clock mode not taken from idle clock level");

   property p_need_fall;
      @(posedge clock) disable iff (!rstn)
         !r_reg.armed |=> !cmd_valid;
   endproperty
   a_need_fall: assert property (p_need_fall)
      else $error("command taken without a select fall");

   property p_buf_page_zero;
      @(posedge clock) disable iff (!rstn)
         (cmd_valid && !r_reg.info.use_page) |-> (cmd_page == '0);
   endproperty
   a_buf_page_zero: assert property (p_buf_page_zero)
      else $error("page bits used by a buffer command");

   property p_standby;
      @(posedge clock) disable iff (!rstn)
         (cs_s && !por_s) |=> standby;
   endproperty
   a_standby: assert property (p_standby)
      else $error("not idle while deselected");

   property p_dummy_done;
      @(posedge clock) disable iff (!rstn)
         s_dummy_to_data |-> cmd_valid;
   endproperty
   a_dummy_done: assert property (p_dummy_done)
      else $error("data phase without header pulse");
endmodule

// File: sim/sfc_host.sv
// Host link model: select, serial clock and data-in, 400 ns bit time
module sfc_host (
   output logic cs_n, // Device select, active low
   output logic sck, // Serial clock
   output logic si, // Serial data to the device
   input wire logic so // Serial data from the device, z when released
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time half_period = 200;
   logic [7:0] rx_q[$];
   initial begin
      cs_n = 1'b1;
      sck = 1'b1;
      si = 1'b0;
   end
   // Whole bytes, data moves while the clock is low, sampled on its rise
   task automatic frame(input logic [7:0] tx[$], input bit m3, input bit nf);
      logic [7:0] r;
      sck = m3;
      #half_period;
      if (!nf) cs_n = 1'b0;
      #half_period;
      rx_q.delete();
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            sck = 1'b0;
            si = tx[i][b];
            #half_period;
            sck = 1'b1;
            r[b] = so;
            #half_period;
         end
         rx_q.push_back(r);
      end
      sck = m3;
      #half_period;
      cs_n = 1'b1;
      // Released line must not look like held data
      si = ~si;
      #half_period;
   endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the serial command framer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // Power-up waits in clock cycles, scaled down to keep the run short
   localparam int supply_to_select_delay = 40;
   localparam int powerup_write_delay = 200;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic por_active = 1'b1;
   logic [7:0] rd_data = 8'h00;
   logic rd_req, so_out, so_oe_n, cmd_valid, wr_valid, frame_end;
   logic mode3, standby, cs_n, sck, si;
   logic [7:0] cmd_opcode, wr_data;
   logic [sfc_pkg::PAGE_W-1:0] cmd_page;
   logic [sfc_pkg::BYTE_W-1:0] cmd_byte;
   wire so_pin = (so_oe_n === 1'b0) ? so_out : 1'bz;
   logic [27:0] got_cmd[$];
   logic [7:0] got_wr[$];
   int mismatches = 0;
   int n_tests = 0;
   int n_end = 0;
   // Opcode, address kind, dummy bytes, reads, takes data
   // Kind: 1 page and byte, 2 page, 3 byte, 4 all ignored, 0 none,
   // 5 top eight page bits, 6 top three page bits
   int tbl[30][5] = '{'{8'h03,1,0,1,0}, '{8'h0b,1,1,1,0}, '{8'hd2,1,4,1,0},
      '{8'h50,5,0,0,0}, '{8'h7c,6,0,0,0},
      '{8'he8,1,4,1,0}, '{8'h82,1,0,0,1}, '{8'h85,1,0,0,1}, '{8'h53,2,0,0,0},
      '{8'h55,2,0,0,0}, '{8'h58,2,0,0,0}, '{8'h59,2,0,0,0}, '{8'h60,2,0,0,0},
      '{8'h61,2,0,0,0}, '{8'h81,2,0,0,0}, '{8'h83,2,0,0,0}, '{8'h86,2,0,0,0},
      '{8'h88,2,0,0,0}, '{8'h89,2,0,0,0}, '{8'h84,3,0,0,1}, '{8'h87,3,0,0,1},
      '{8'hd1,3,0,1,0}, '{8'hd3,3,0,1,0}, '{8'hd4,3,1,1,0}, '{8'hd6,3,1,1,0},
      '{8'h77,4,0,0,0}, '{8'h9f,0,0,1,0}, '{8'hd7,0,0,1,0}, '{8'hb9,0,0,0,0},
      '{8'hab,0,0,0,0}};
   initial forever #25 clock = ~clock;
   sfc_framer i_dut (.clock(clock), .rstn(rstn), .cs_n_pin(cs_n),
      .sck_pin(sck), .si_pin(si), .por_active(por_active),
      .rd_data(rd_data), .rd_req(rd_req), .so_out(so_out),
      .so_oe_n(so_oe_n), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
      .cmd_page(cmd_page), .cmd_byte(cmd_byte), .wr_valid(wr_valid),
      .wr_data(wr_data), .frame_end(frame_end), .mode3(mode3),
      .standby(standby));
   sfc_host i_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so_pin));
   // Each taken byte is followed by a new one, so a shifted start shows
   // Advanced on the edge that takes the byte, so the take sees the old one
   always @(posedge clock)
      if (rd_req === 1'b1) rd_data <= rd_data + 8'h01;
   always @(posedge clock) begin
      if (cmd_valid === 1'b1)
         got_cmd.push_back({cmd_opcode, cmd_page, cmd_byte});
      if (wr_valid === 1'b1) got_wr.push_back(wr_data);
      if (frame_end === 1'b1) n_end++;
   end
   task automatic check(input string what, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", what, e, g);
         mismatches++;
      end
   endtask
   task automatic final_report();
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic run(input int r, input bit nf);
      logic [7:0] tx[$];
      logic [7:0] w[$];
      logic [23:0] a;
      logic [7:0] rd0;
      bit m;
      int k;
      int hdr;
      int e0;
      a = 24'($urandom);
      e0 = n_end;
      m = 1'($urandom);
      k = tbl[r][1];
      rd0 = rd_data;
      got_cmd.delete();
      got_wr.delete();
      tx.push_back(8'(tbl[r][0]));
      if (k != 0) tx = {tx, a[23:16], a[15:8], a[7:0]};
      repeat (tbl[r][2]) tx.push_back(8'($urandom));
      hdr = tx.size();
      repeat (2 * (tbl[r][3] + tbl[r][4])) tx.push_back(8'($urandom));
      if (tbl[r][4] != 0) w = tx[hdr:$];
      i_host.frame(tx, m, nf);
      repeat (4) @(negedge clock);
      check("cmd count", (nf || por_active) ? 0 : 1, got_cmd.size());
      check("frame end", (nf || por_active) ? 0 : 1, n_end - e0);
      if (got_cmd.size() == 0) return;
      check("opcode", tbl[r][0], got_cmd[0][27:20]);
      check("page", (k == 1 || k == 2) ? a[19:9] :
         (k == 5) ? (a[19:9] & 11'h7f8) :
         (k == 6) ? (a[19:9] & 11'h700) : 0, got_cmd[0][19:9]);
      check("byte", (k == 1 || k == 3) ? a[8:0] : 0, got_cmd[0][8:0]);
      check("mode", m, mode3);
      check("standby", 1, standby);
      check("write count", w.size(), got_wr.size());
      foreach (w[i]) check("write data", w[i], got_wr[i]);
      if (tbl[r][3] != 0) check("first read", rd0, i_host.rx_q[hdr]);
   endtask
   initial begin
      void'($urandom(32'h7445));
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      rd_data = 8'($urandom);
      @(negedge clock);
      check("mode after reset", 1, mode3);
      check("out enable after reset", 1, so_oe_n);
      run(0, 0);
      por_active = 1'b0;
      repeat (supply_to_select_delay) @(negedge clock);
      check("standby", 1, standby);
      i_host.cs_n = 1'b0;
      rstn = 1'b0;
      repeat (10) @(negedge clock);
      rstn = 1'b1;
      run(0, 1);
      repeat (powerup_write_delay) @(negedge clock);
      for (int n = 0; n < 2; n++)
         foreach (tbl[r]) run(r, 0);
      final_report();
   end
   initial begin
      #4ms;
      mismatches++;
      final_report();
   end
endmodule
